// >>> rtl/slt_map.vh
// constants for the serial link transmitter: apb map, fields, timing
// assumes: included by the transmitter and its fifo, defines only
`ifndef SLT_MAP_VH
`define SLT_MAP_VH
// apb register byte offsets
`define SLT_CTRL_OFF     12'h000
`define SLT_STATUS_OFF   12'h004
`define SLT_LFSR_OFF     12'h008
`define SLT_SYMBOL_OFF   12'h00C
// control register fields and reset value
`define SLT_CTRL_BYPASS  0
`define SLT_CTRL_SELFT   1
`define SLT_CTRL_RESET   2'h0
// status register fields
`define SLT_ST_RD        0
`define SLT_ST_NEMPTY    1
`define SLT_ST_FULL      2
`define SLT_ST_PEND      3
// bit clock and byte timing: one bit per pclk, ten bits per byte
`define SLT_BITS_PER_BYTE 4'hA
`define SLT_LAST_BIT      4'h9
// read strobe low window inside the byte, in bit counts
`define SLT_RS_LOW_FIRST  4'h0
`define SLT_RS_LOW_LAST   4'h4
// self-test generator seed, nonzero
`define SLT_LFSR_SEED     9'h1FF
// comma fill byte, k28.5, sent through the encoder as a special
`define SLT_COMMA_BYTE    8'hBC
// violation symbol, negative disparity form, bit a first
`define SLT_VIOL_SYM      10'h3C8
// symbol register reset value
`define SLT_SYM_RESET     10'h000
`endif

// >>> rtl/slt_fifo.v
// small synchronous fifo with valid and ready on both sides
// assumes: one clock, asynchronous active low reset, depth a power of two
`timescale 1ns/1ns
`include "slt_map.vh"
module slt_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
   reg [AW-1:0]    wr_q;            // write pointer
   reg [AW-1:0]    rd_q;            // read pointer
   reg [AW:0]      cnt_q;           // words held
   wire            push;            // word accepted
   wire            pop;             // word released

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage write, no reset needed on data
   always @(posedge pclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// >>> rtl/slt_tx.v
// serial link transmitter: byte load, 8b/10b encoder, serialiser
// assumes: pclk is the bit clock, pins synchronous to it, apb slave
//
// Summary of operation
// - load-now low at byte edge captures inputs
// - load-next low captures inputs at next edge
// - no load at byte edge sends comma
// - self-test turns input register into 511-state lfsr
// - special select picks special table, else data
// - violation request sends the fixed violation symbol, raw bit j in bypass mode
// - bypass mode sends raw ten bits, a first
// - shifter takes one symbol per ten bits
// - shifter load timed only by byte counter
// - all three outputs carry the same stream while outputs-off is low
// - outputs-off forces a and b low, c runs
// - outputs-off unsynchronised, acts within bit times
// - byte-rate read strobe from internal counter
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "slt_map.vh"
module slt_tx #(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW    = 2
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [7:0]  parallel_data_in,
   input  wire        special_char_select,
   input  wire        send_violation,
   input  wire        load_now_n,
   input  wire        load_next_n,
   output reg         load_ready,
   input  wire        optical_outputs_off,
   output reg         fifo_read_strobe_n,
   output reg         serial_out_a,
   output reg         serial_out_b,
   output reg         serial_out_c
);
   // byte timing
   reg  [3:0]  bitcnt_q;        // bit position inside the byte
   wire        byte_tick;       // last bit of the byte: byte edge
   // control
   reg  [1:0]  ctrl_q;          // bypass and self-test bits
   wire        bypass;          // encoder bypassed
   wire        selftest;        // lfsr drives the symbol stream
   // load path
   reg         pend_q;          // load-next seen, capture next edge
   wire        push_now;        // capture at this byte edge
   wire [9:0]  in_word;         // {violation, special, data}
   wire        f_in_ready;      // fifo has room
   wire [9:0]  f_out;           // head word
   wire        f_valid;         // head present
   // encoder state
   reg         rd_q;            // running disparity, 1 = positive
   reg  [8:0]  lfsr_q;          // self-test generator
   reg  [9:0]  sym_q;           // last symbol sent, a in bit 9
   reg  [9:0]  shift_q;         // serialiser, msb goes out first
   reg         off_q;           // registered outputs-off level
   // symbol selection
   reg  [7:0]  sel_d;           // byte to encode
   reg         sel_k;           // special flag
   reg         sel_v;           // violation flag
   reg         sel_raw;         // raw ten-bit word
   reg  [9:0]  raw_d;           // raw word, a in bit 9
   reg  [10:0] enc;             // {new disparity, symbol}
   reg  [9:0]  sym_d;           // symbol loaded into the shifter
   reg         rd_d;            // disparity after this symbol
   wire [9:0]  raw_symbol_bits; // fifo head, reordered a first
   // apb
   wire        acc;             // access phase
   reg  [31:0] rdata_d;         // read mux
   reg         hit_d;           // address mapped

   assign byte_tick = (bitcnt_q == `SLT_LAST_BIT);
   assign bypass    = ctrl_q[`SLT_CTRL_BYPASS];
   assign selftest  = ctrl_q[`SLT_CTRL_SELFT];
   assign in_word   = {send_violation, special_char_select,
                       parallel_data_in};
   // immediate load, or the edge after a load-next request
   assign push_now  = byte_tick & (~load_now_n | pend_q);

   // raw word: data bit 0 is bit a, violation input is bit j
   genvar gi;
   generate
      for (gi = 0; gi < 10; gi = gi + 1) begin : g_rev
         assign raw_symbol_bits[9-gi] = f_out[gi];
      end
   endgenerate

   // input buffer between the byte source and the encoder
   slt_fifo #(
      .WIDTH (10),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_data   (in_word),
      .in_valid  (push_now & ~selftest),
      .in_ready  (f_in_ready),
      .out_data  (f_out),
      .out_valid (f_valid),
      .out_ready (byte_tick & ~selftest)
   );

   // 8b/10b encode of one byte; returns {new disparity, abcdeifghj}
   function [10:0] enc_sym;
      input [7:0] d;
      input       k;
      input       rd;
      reg [5:0] s6;
      reg [3:0] s4;
      reg [4:0] x;
      reg [2:0] y;
      reg       rdm;
      reg       rdo;
      reg       alt;
      reg [2:0] n6;
      reg [2:0] n4;
      integer   i;
      begin
         x = d[4:0];
         y = d[7:5];
         // 5b/6b, negative disparity column
         case (x)
            5'd0:  s6 = 6'b100111;
            5'd1:  s6 = 6'b011101;
            5'd2:  s6 = 6'b101101;
            5'd3:  s6 = 6'b110001;
            5'd4:  s6 = 6'b110101;
            5'd5:  s6 = 6'b101001;
            5'd6:  s6 = 6'b011001;
            5'd7:  s6 = 6'b111000;
            5'd8:  s6 = 6'b111001;
            5'd9:  s6 = 6'b100101;
            5'd10: s6 = 6'b010101;
            5'd11: s6 = 6'b110100;
            5'd12: s6 = 6'b001101;
            5'd13: s6 = 6'b101100;
            5'd14: s6 = 6'b011100;
            5'd15: s6 = 6'b010111;
            5'd16: s6 = 6'b011011;
            5'd17: s6 = 6'b100011;
            5'd18: s6 = 6'b010011;
            5'd19: s6 = 6'b110010;
            5'd20: s6 = 6'b001011;
            5'd21: s6 = 6'b101010;
            5'd22: s6 = 6'b011010;
            5'd23: s6 = 6'b111010;
            5'd24: s6 = 6'b110011;
            5'd25: s6 = 6'b100110;
            5'd26: s6 = 6'b010110;
            5'd27: s6 = 6'b110110;
            5'd28: s6 = 6'b001110;
            5'd29: s6 = 6'b101110;
            5'd30: s6 = 6'b011110;
            default: s6 = 6'b101011;
         endcase
         if (k && x == 5'd28) begin
            s6 = 6'b001111;
         end
         n6 = 3'd0;
         for (i = 0; i < 6; i = i + 1) begin
            n6 = n6 + {2'b00, s6[i]};
         end
         // pick the form that pulls disparity back
         if (s6 == 6'b111000) begin
            if (rd) begin
               s6 = 6'b000111;
            end
            rdm = rd;
         end else if (n6 == 3'd3) begin
            rdm = rd;
         end else begin
            if (rd) begin
               s6 = ~s6;
            end
            rdm = ~rd;
         end
         // 3b/4b, negative disparity column
         case (y)
            3'd0:    s4 = 4'b1011;
            3'd1:    s4 = 4'b1001;
            3'd2:    s4 = 4'b0101;
            3'd3:    s4 = 4'b1100;
            3'd4:    s4 = 4'b1101;
            3'd5:    s4 = 4'b1010;
            3'd6:    s4 = 4'b0110;
            default: s4 = 4'b1110;
         endcase
         // alternate x.7 avoids a run of five in a row
         alt = (y == 3'd7) && (k ||
               (!rdm && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
               ( rdm && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
         if (alt) begin
            s4 = 4'b0111;
         end
         // k28 balanced tails flip when the 6b part left rd negative
         if (k && x == 5'd28 && !rdm &&
             (y == 3'd1 || y == 3'd2 || y == 3'd5 || y == 3'd6)) begin
            s4 = ~s4;
         end
         n4 = 3'd0;
         for (i = 0; i < 4; i = i + 1) begin
            n4 = n4 + {2'b00, s4[i]};
         end
         if (y == 3'd3 && !alt) begin
            if (rdm) begin
               s4 = 4'b0011;
            end
            rdo = rdm;
         end else if (n4 == 3'd2) begin
            rdo = rdm;
         end else begin
            if (rdm) begin
               s4 = ~s4;
            end
            rdo = ~rdm;
         end
         enc_sym = {rdo, s6, s4};
      end
   endfunction

   // byte counter of the bit clock: the only shifter load timing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bitcnt_q <= 4'h0;
      end else if (byte_tick) begin
         bitcnt_q <= 4'h0;
      end else begin
         bitcnt_q <= bitcnt_q + 4'h1;
      end
   end

   // load-next request waits for the following byte edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
      end else if (byte_tick) begin
         pend_q <= ~load_next_n;
      end
   end

   // choose what the next byte time carries
   always @* begin
      sel_d   = `SLT_COMMA_BYTE;
      sel_k   = 1'b1;
      sel_v   = 1'b0;
      sel_raw = 1'b0;
      raw_d   = raw_symbol_bits;
      if (selftest) begin
         // generator covers data, specials and violations
         sel_d = lfsr_q[7:0];
         sel_k = lfsr_q[8];
         sel_v = lfsr_q[8] & (lfsr_q[4:0] == 5'h00);
      end else if (f_valid) begin
         sel_d   = f_out[7:0];
         sel_k   = f_out[8];
         sel_v   = f_out[9];
         sel_raw = bypass;
      end
      // an empty buffer keeps the encoded comma above, bypass or not,
      // so the fill flips disparity like any other coded byte
      // table select by the special flag
      enc = enc_sym(sel_d, sel_k, rd_q);
      if (sel_raw) begin
         sym_d = raw_d;
         rd_d  = rd_q;
      end else if (sel_v) begin
         // fixed violation, disparity left unchanged
         sym_d = rd_q ? ~`SLT_VIOL_SYM : `SLT_VIOL_SYM;
         rd_d  = rd_q;
      end else begin
         sym_d = enc[9:0];
         rd_d  = enc[10];
      end
   end

   // symbol load once per byte and running disparity update
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q    <= 1'b0;
         sym_q   <= `SLT_SYM_RESET;
         shift_q <= `SLT_SYM_RESET;
      end else if (byte_tick) begin
         rd_q    <= rd_d;
         sym_q   <= sym_d;
         shift_q <= sym_d;
      end else begin
         shift_q <= {shift_q[8:0], 1'b0};
      end
   end

   // self-test lfsr, x^9 + x^5 + 1, 511 states, steps per byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_q <= `SLT_LFSR_SEED;
      end else if (!selftest) begin
         lfsr_q <= `SLT_LFSR_SEED;
      end else if (byte_tick) begin
         lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
      end
   end

   // serial outputs from the shifter, a and b gated by outputs-off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_q        <= 1'b0;
         serial_out_a <= 1'b0;
         serial_out_b <= 1'b0;
         serial_out_c <= 1'b0;
      end else begin
         // sampled every bit, so it may cut a symbol mid-way
         off_q        <= optical_outputs_off;
         serial_out_a <= shift_q[9] & ~off_q;
         serial_out_b <= shift_q[9] & ~off_q;
         serial_out_c <= shift_q[9];
      end
   end

   // read strobe low over a fixed part of each byte time
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_read_strobe_n <= 1'b1;
         load_ready         <= 1'b0;
      end else begin
         fifo_read_strobe_n <= ~((bitcnt_q >= `SLT_RS_LOW_FIRST) &&
                                 (bitcnt_q <  `SLT_RS_LOW_LAST));
         load_ready         <= f_in_ready & ~selftest;
      end
   end

   // apb decode and read mux
   assign acc = psel & penable;
   always @* begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      case (paddr)
         `SLT_CTRL_OFF: begin
            rdata_d[1:0] = ctrl_q;
         end
         `SLT_STATUS_OFF: begin
            rdata_d[`SLT_ST_RD]     = rd_q;
            rdata_d[`SLT_ST_NEMPTY] = f_valid;
            rdata_d[`SLT_ST_FULL]   = ~f_in_ready;
            rdata_d[`SLT_ST_PEND]   = pend_q;
         end
         `SLT_LFSR_OFF: begin
            rdata_d[8:0] = lfsr_q;
         end
         `SLT_SYMBOL_OFF: begin
            rdata_d[9:0] = sym_q;
         end
         default: begin
            hit_d = 1'b0;
         end
      endcase
   end

   // apb slave: one wait-free answer in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `SLT_CTRL_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_d;
         if (psel & ~penable & ~pwrite) begin
            prdata <= rdata_d;
         end
         // write takes effect on the completing edge
         if (acc & pready & pwrite & (paddr == `SLT_CTRL_OFF)) begin
            ctrl_q <= pwdata[1:0];
         end
      end
   end
endmodule

// >>> tb/slt_tx_properties.sv
// checker for the transmitter: apb timing, strobe shape, output gating
// assumes: bound to slt_tx, single clock pclk, async reset presetn
`timescale 1ns/1ns
module slt_tx_properties (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire optical_outputs_off,
   input wire fifo_read_strobe_n,
   input wire serial_out_a,
   input wire serial_out_b,
   input wire serial_out_c
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // strobe stays low four bit times, then high six
   sequence s_low;
      (!fifo_read_strobe_n)[*4] ##1 fifo_read_strobe_n;
   endsequence
   sequence s_high;
      fifo_read_strobe_n[*6] ##1 !fifo_read_strobe_n;
   endsequence
   property p_rs_low;
      $fell(fifo_read_strobe_n) |-> s_low;
   endproperty
   a_rs_low: assert property (p_rs_low)
      else $error("read strobe low width wrong");
   property p_rs_high;
      $rose(fifo_read_strobe_n) |-> s_high;
   endproperty
   a_rs_high: assert property (p_rs_high)
      else $error("read strobe high width wrong");
   property p_rs_period;
      $fell(fifo_read_strobe_n) |-> ##10 $fell(fifo_read_strobe_n);
   endproperty
   a_rs_period: assert property (p_rs_period)
      else $error("byte period is not ten bits");
   // apb slave answers in the first access cycle
   property p_zero_wait;
      psel && !penable |=> pready;
   endproperty
   a_zero_wait: assert property (p_zero_wait)
      else $error("pready late");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready longer than one cycle");
   property p_err_cause;
      pslverr |-> pready && psel && penable;
   endproperty
   a_err_cause: assert property (p_err_cause)
      else $error("pslverr outside an access");
   // gating of outputs a and b, c untouched
   property p_off_gate;
      optical_outputs_off[*4] |-> !serial_out_a && !serial_out_b;
   endproperty
   a_off_gate: assert property (p_off_gate)
      else $error("outputs a or b not forced low");
   property p_on_copy;
      (!optical_outputs_off)[*4] |->
         serial_out_a == serial_out_c && serial_out_b == serial_out_c;
   endproperty
   a_on_copy: assert property (p_on_copy)
      else $error("serial outputs differ");
endmodule

// >>> tb/slt_src.sv
// byte source model: paced by the read strobe, one word per byte slot
// assumes: byte edge comes nine bit times after the strobe falls
`timescale 1ns/1ns
module slt_src (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        fifo_read_strobe_n,
   output logic [7:0] parallel_data_in    = 8'h00,
   output logic       special_char_select = 1'b0,
   output logic       send_violation      = 1'b0,
   output logic       load_now_n          = 1'b1,
   output logic       load_next_n         = 1'b1
);
   logic [10:0] q[$];     // words {next, violation, special, data}
   int          gap = 0;  // idle byte slots after each word
   int          ph;       // bit times since the strobe fell
   int          idle;     // idle slots still to skip
   logic        prev_s;   // strobe one cycle back
   logic        pend;     // a load-next word waits for its data edge
   logic [10:0] w;        // word in flight
   task push(input logic [10:0] x);
      q.push_back(x);
   endtask
   // drive one cycle ahead of the byte edge, release right after it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 0;
         prev_s <= 1'b1;
         pend <= 1'b0;
         idle <= 0;
         load_now_n <= 1'b1;
         load_next_n <= 1'b1;
      end else begin
         prev_s <= fifo_read_strobe_n;
         ph <= (prev_s && !fifo_read_strobe_n) ? 1 : ph + 1;
         if (ph == 7) begin
            if (pend) begin
               // data for the edge after the load-next request
               {send_violation, special_char_select, parallel_data_in}
                  <= w[9:0];
               pend <= 1'b0;
            end else if (idle > 0) begin
               idle <= idle - 1;
            end else if (q.size() > 0) begin
               w = q.pop_front();
               // a load-next request carries decoy data
               {send_violation, special_char_select, parallel_data_in}
                  <= w[10] ? ~w[9:0] : w[9:0];
               load_now_n <= w[10];
               load_next_n <= !w[10];
               pend <= w[10];
               idle <= gap;
            end
         end else if (ph == 8) begin
            // released lines show the inverse, never the stale value
            load_now_n <= 1'b1;
            load_next_n <= 1'b1;
            {send_violation, special_char_select, parallel_data_in}
               <= ~{send_violation, special_char_select, parallel_data_in};
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// top bench: apb traffic, byte source, serial stream deframer and checks
// assumes: slt_tx with its fifo, byte source model, checker bound below
`timescale 1ns/1ns
`include "slt_map.vh"
module testbench;
   localparam logic [9:0] COMMA = 10'h0FA; // fill, negative form
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [7:0]  parallel_data_in;
   logic        special_char_select, send_violation, load_now_n;
   logic        load_next_n, load_ready, optical_outputs_off;
   logic        fifo_read_strobe_n, serial_out_a, serial_out_b;
   logic        serial_out_c, err, aligned, rd_pos, idle_chk;
   logic [10:0] exp_q[$];  // {flips with disparity, negative form}
   logic [9:0]  sh, ev;
   int          n_errors, checks_done, bitn, cyc, n;
   slt_tx slt_tx_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .parallel_data_in,
      .special_char_select, .send_violation, .load_now_n, .load_next_n,
      .load_ready, .optical_outputs_off, .fifo_read_strobe_n,
      .serial_out_a, .serial_out_b, .serial_out_c);
   slt_src slt_src_i (.pclk, .presetn, .fifo_read_strobe_n,
      .parallel_data_in, .special_char_select, .send_violation,
      .load_now_n, .load_next_n);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_sym(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t sym=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, waits for pready; the hang guard bounds it
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic send(input logic [10:0] w, input logic [10:0] e);
      exp_q.push_back(e);
      slt_src_i.push(w);
   endtask
   task automatic drain;
      int k;
      k = 0;
      while (exp_q.size() > 0 && k < 400) begin
         @(posedge pclk);
         k++;
      end
      cmp32(exp_q.size(), 0);
   endtask
   // judge one symbol; fill commas are skipped while words are due
   task automatic take(input logic [9:0] s);
      logic [9:0] fill;
      fill = rd_pos ? ~COMMA : COMMA;
      if (exp_q.size() > 0) begin
         ev = (exp_q[0][10] && rd_pos) ? ~exp_q[0][9:0] : exp_q[0][9:0];
         if (s !== fill || ev === fill) begin
            cmp_sym(s, ev);
            void'(exp_q.pop_front());
         end
      end else if (idle_chk) begin
         cmp_sym(s, fill);
      end
      if ($countones(s) > 5) rd_pos = 1'b1;
      else if ($countones(s) < 5) rd_pos = 1'b0;
   endtask
   // deframe output c on the first comma, then every ten bits
   always @(posedge pclk) begin
      if (presetn) begin
         sh = {sh[8:0], serial_out_c};
         bitn++;
         if (!aligned && sh === COMMA) begin
            aligned = 1'b1;
            bitn = 0;
            rd_pos = 1'b1;
         end else if (aligned && bitn == 10) begin
            bitn = 0;
            take(sh);
         end
      end
   end
   task print_verdict;
      if (n_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, optical_outputs_off} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      {aligned, idle_chk} = 2'b01;
      {n_errors, checks_done, bitn, cyc} = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // register map and refused accesses
      apb(1'b0, `SLT_CTRL_OFF, 32'h0);
      cmp32(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      cmp32(rd, 32'h0);
      cmp32(err, 1'b1);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      cmp32(err, 1'b1);
      apb(1'b1, `SLT_CTRL_OFF, 32'h1);
      apb(1'b0, `SLT_CTRL_OFF, 32'h0);
      cmp32(rd, 32'h1);
      apb(1'b1, `SLT_CTRL_OFF, 32'h0);
      apb(1'b0, `SLT_STATUS_OFF, 32'h0);
      cmp32(rd & 32'hFFFF_FFFE, 32'h0);
      repeat (60) @(posedge pclk);
      // back to back encoded words
      cmp32(load_ready, 1'b1);
      send({3'b000, 8'h00}, {1'b1, 10'h274});
      send({3'b001, 8'hBC}, {1'b1, COMMA});
      send({3'b000, 8'hB5}, {1'b0, 10'h2AA});
      send({3'b010, 8'h00}, {1'b1, `SLT_VIOL_SYM});
      send({3'b000, 8'h4A}, {1'b0, 10'h155});
      drain();
      // slow source, then load-next requests
      slt_src_i.gap = 2;
      send({3'b000, 8'hB5}, {1'b0, 10'h2AA});
      send({3'b000, 8'h00}, {1'b1, 10'h274});
      drain();
      slt_src_i.gap = 0;
      send({3'b100, 8'h4A}, {1'b0, 10'h155});
      send({3'b100, 8'h00}, {1'b1, 10'h274});
      drain();
      // raw ten bits, a first
      apb(1'b1, `SLT_CTRL_OFF, 32'h1);
      send({3'b010, 8'h0F}, {1'b0, 10'h3C1});
      send({3'b001, 8'hAA}, {1'b0, 10'h156});
      drain();
      apb(1'b1, `SLT_CTRL_OFF, 32'h0);
      // outputs a and b forced low while c keeps running
      optical_outputs_off <= 1'b1;
      repeat (4) @(posedge pclk);
      n = 0;
      repeat (20) begin
         @(posedge pclk);
         cmp32({serial_out_a, serial_out_b}, 2'b00);
         n += serial_out_c;
      end
      cmp32(n > 0 && n < 20, 1'b1);
      optical_outputs_off <= 1'b0;
      // self-test: loads refused, generator repeats after 511 bytes
      idle_chk = 1'b0;
      apb(1'b1, `SLT_CTRL_OFF, 32'h2);
      repeat (2) @(posedge pclk);
      cmp32(load_ready, 1'b0);
      apb(1'b0, `SLT_LFSR_OFF, 32'h0);
      v = rd;
      repeat (5107) @(posedge pclk);
      apb(1'b0, `SLT_LFSR_OFF, 32'h0);
      cmp32(rd, v);
      repeat (97) @(posedge pclk);
      apb(1'b0, `SLT_LFSR_OFF, 32'h0);
      cmp32(rd === v, 1'b0);
      apb(1'b1, `SLT_CTRL_OFF, 32'h0);
      repeat (40) @(posedge pclk);
      idle_chk = 1'b1;
      repeat (40) @(posedge pclk);
      print_verdict();
   end
endmodule
bind slt_tx slt_tx_properties slt_tx_properties_i (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .optical_outputs_off,
   .fifo_read_strobe_n, .serial_out_a, .serial_out_b, .serial_out_c);
